// ==== inc/clk_div_bank_pkg.sv ====
// Shared constants, register layout and decode helpers for the channel clock divider bank
`default_nettype none
package clk_div_bank_pkg;
	// Register indexes; the byte address is four times the index
	localparam logic [11:0] IDX_STAGE1_COUNTS = 12'h19e;
	localparam logic [11:0] IDX_STAGE2_COUNTS = 12'h1a0;
	localparam logic [11:0] IDX_CHANNEL_CTRL = 12'h1a1;
	localparam logic [11:0] IDX_DUTY_CTRL = 12'h1a2;
	localparam logic [11:0] IDX_PRESCALER_RATIO = 12'h1e0;
	localparam logic [11:0] IDX_INPUT_CTRL = 12'h1e1;
	localparam logic [11:0] IDX_SOFT_SYNC = 12'h230;
	localparam logic [11:0] IDX_UPDATE = 12'h232;
	localparam logic [11:0] IDX_STATUS = 12'h240;
	localparam int ADDR_W = 14;
	localparam int IDX_LSB = 2;

	// Reset values
	localparam logic [7:0] RST_COUNTS = 8'h00;
	localparam logic [7:0] RST_CTRL = 8'h00;
	localparam logic [7:0] RST_RATIO = 8'h02;

	// Readable bit masks; reserved bits read as zero
	localparam logic [7:0] MASK_COUNTS = 8'hff;
	localparam logic [7:0] MASK_CHANNEL = 8'h3f;
	localparam logic [7:0] MASK_ONE_BIT = 8'h01;
	localparam logic [7:0] MASK_RATIO = 8'h07;
	localparam logic [7:0] MASK_INPUT = 8'h1f;

	// Field positions
	localparam int LOW_MSB = 7;
	localparam int LOW_LSB = 4;
	localparam int HIGH_MSB = 3;
	localparam int HIGH_LSB = 0;
	localparam int CH_BYPASS2 = 5;
	localparam int CH_BYPASS1 = 4;
	localparam int CH_NOSYNC = 3;
	localparam int CH_FORCE = 2;
	localparam int CH_START2 = 1;
	localparam int CH_START1 = 0;
	localparam int DUTY_OFF = 0;
	localparam int IN_PD_SECTION = 4;
	localparam int IN_PD_OSC_IF = 3;
	localparam int IN_PD_BOTH = 2;
	localparam int IN_SEL_OSC = 1;
	localparam int IN_BYPASS = 0;
	localparam int SOFT_SYNC_BIT = 0;
	localparam int UPDATE_BIT = 0;

	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Prescaler codes at or above this value hold the output static
	localparam logic [2:0] RATIO_STATIC_MIN = 3'h5;
	localparam logic [2:0] RATIO_BASE = 3'h2;

	typedef enum logic [3:0] {
		SEL_NONE, SEL_STAGE1, SEL_STAGE2, SEL_CHANNEL, SEL_DUTY,
		SEL_RATIO, SEL_INPUT, SEL_SOFT_SYNC, SEL_UPDATE, SEL_STATUS
	} reg_sel_t;

	// Word index to register select, shared by the read and write paths
	function automatic reg_sel_t decode_index(input logic [11:0] idx);
		case (idx)
			IDX_STAGE1_COUNTS: decode_index = SEL_STAGE1;
			IDX_STAGE2_COUNTS: decode_index = SEL_STAGE2;
			IDX_CHANNEL_CTRL: decode_index = SEL_CHANNEL;
			IDX_DUTY_CTRL: decode_index = SEL_DUTY;
			IDX_PRESCALER_RATIO: decode_index = SEL_RATIO;
			IDX_INPUT_CTRL: decode_index = SEL_INPUT;
			IDX_SOFT_SYNC: decode_index = SEL_SOFT_SYNC;
			IDX_UPDATE: decode_index = SEL_UPDATE;
			IDX_STATUS: decode_index = SEL_STATUS;
			default: decode_index = SEL_NONE;
		endcase
	endfunction
endpackage
`default_nettype wire

// ==== logic/clk_div_stage.sv ====
// One divider stage with separate low and high phase lengths, start level and bypass
`timescale 1ns/1ps
`default_nettype none
module clk_div_stage (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic hold,
	input wire logic bypass,
	input wire logic startHigh,
	input wire logic [3:0] lowCount,
	input wire logic [3:0] highCount,
	input wire logic inLevel,
	input wire logic inTick,
	output logic outLevel,
	output logic outTick
);
	logic [3:0] cnt_q;
	logic level_q;
	logic phaseEnd;

	// Current phase ends after its count plus one input cycles
	assign phaseEnd = inTick && (cnt_q == (level_q ? highCount : lowCount));

	// Held or bypassed logic sits idle at its start level, ready to restart
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 4'h0;
			level_q <= 1'b0;
		end else if (hold || bypass) begin
			cnt_q <= 4'h0;
			level_q <= startHigh;
		end else if (phaseEnd) begin
			cnt_q <= 4'h0;
			level_q <= ~level_q;
		end else if (inTick) begin
			cnt_q <= cnt_q + 4'h1;
		end
	end

	// Bypass hands the input straight through; tick marks each rising output edge
	assign outLevel = bypass ? inLevel : level_q;
	assign outTick = bypass ? inTick : (phaseEnd && !level_q && !hold);
endmodule
`default_nettype wire

// ==== logic/clk_prescaler.sv ====
// Input prescaler: divide by two to six, static output, or bypass
`timescale 1ns/1ps
`default_nettype none
module clk_prescaler (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic hold,
	input wire logic bypass,
	input wire logic [2:0] ratio,
	input wire logic inLevel,
	input wire logic inTick,
	output logic outLevel,
	output logic outTick
);
	logic [2:0] cnt_q;
	logic [2:0] cnt_d;
	logic level_q;
	logic isStatic;
	logic [2:0] divide;
	logic [2:0] highLen;
	logic wrap;

	// Code n divides by n plus two; high phase is the lower half
	assign isStatic = (ratio >= clk_div_bank_pkg::RATIO_STATIC_MIN);
	assign divide = ratio + clk_div_bank_pkg::RATIO_BASE;
	assign highLen = {1'b0, divide[2:1]};
	assign wrap = (cnt_q == divide - 3'h1);
	assign cnt_d = wrap ? 3'h0 : cnt_q + 3'h1;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 3'h0;
			level_q <= 1'b0;
		end else if (hold || isStatic || bypass) begin
			cnt_q <= 3'h0;
			level_q <= 1'b0;
		end else if (inTick) begin
			cnt_q <= cnt_d;
			level_q <= (cnt_d < highLen);
		end
	end

	// Without bypass, static codes hold the output low and stop all ticks
	assign outLevel = bypass ? inLevel : level_q;
	assign outTick = bypass ? inTick : (inTick && wrap && !hold && !isStatic);
endmodule
`default_nettype wire

// ==== logic/channel_clock_divider_bank.sv ====
// Channel clock divider bank: AXI4-Lite registers, input selection, prescaler and two stages
//
// Contract
// - Stage two stays low for low count plus one input cycles.
// - Stage two stays high for high count plus one input cycles.
// - Stage-two bypass idles that stage and passes its input through.
// - Stage-one bypass idles that stage and passes its input through.
// - Sync-ignore clear obeys chip sync; set disregards it.
// - Force bit sets output level, only with sync-ignore set.
// - Stage two starts high when its start bit is one.
// - Stage one starts high when its start bit is one.
// - Duty-cycle correction runs unless its disable bit is one.
// - Ratio codes divide by two to six; codes five to seven hold output static.
// - Input-section power-down stops input buffer, prescaler and clock tree.
// - Oscillator-interface power-down cuts the oscillator path to distribution.
// - Combined power-down stops oscillator path and external input.
// - Source bit: zero external clock, one oscillator; no bypass then.
// - Prescaler bypass routes input around it, unless oscillator selected.
// - Writes land in buffers; self-clearing update bit copies them to active.
// - Sync request holds channels static; its release restarts the dividers together.
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module channel_clock_divider_bank (
	input wire logic clk,
	input wire logic rst_n,
	// AXI4-Lite slave
	input wire logic [13:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [13:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Clock sources and chip sync, all asynchronous to clk
	input wire logic extClkIn,
	input wire logic oscClkIn,
	input wire logic syncPin_n,
	// Divided outputs and path controls
	output logic chanClkOut,
	output logic prescaleClkOut,
	output logic dutyCorrectEnable,
	output logic inputSectionPowerDown,
	output logic oscPathPowerDown,
	output logic extInputPowerDown
);
	////////////////////////////////////////////////////////////////////////////////
	// Register state
	logic [7:0] bufStage1_q, bufStage2_q, bufChannel_q, bufDuty_q, bufRatio_q, bufInput_q;
	logic [7:0] actStage1_q, actStage2_q, actChannel_q, actDuty_q, actRatio_q, actInput_q;
	logic softSync_q, updateReq_q;

	logic awHeld_q, wHeld_q;
	logic [11:0] awIdx_q;
	logic [7:0] wByte_q;
	logic wLane0_q, bvalid_q, rvalid_q, doWrite, wrLane;
	logic [1:0] bresp_q, rresp_q;
	logic [31:0] rdata_q;
	clk_div_bank_pkg::reg_sel_t wrSel, rdSel;
	logic [7:0] rdByte, statusByte;

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite write channel
	// Address and data taken independently, none while a response waits
	assign awready = !awHeld_q && !bvalid_q;
	assign wready = !wHeld_q && !bvalid_q;
	assign doWrite = awHeld_q && wHeld_q && !bvalid_q;
	assign wrSel = clk_div_bank_pkg::decode_index(awIdx_q);
	assign wrLane = doWrite && wLane0_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			awHeld_q <= 1'b0;
			awIdx_q <= 12'h000;
		end else if (awvalid && awready) begin
			awHeld_q <= 1'b1;
			awIdx_q <= awaddr[clk_div_bank_pkg::ADDR_W-1:clk_div_bank_pkg::IDX_LSB];
		end else if (doWrite) begin
			awHeld_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wHeld_q <= 1'b0;
			wByte_q <= 8'h00;
			wLane0_q <= 1'b0;
		end else if (wvalid && wready) begin
			wHeld_q <= 1'b1;
			wByte_q <= wdata[7:0];
			wLane0_q <= wstrb[0];
		end else if (doWrite) begin
			wHeld_q <= 1'b0;
		end
	end

	// Response one cycle after both halves are held; unmapped addresses get SLVERR
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bvalid_q <= 1'b0;
			bresp_q <= clk_div_bank_pkg::RESP_OKAY;
		end else if (doWrite) begin
			bvalid_q <= 1'b1;
			bresp_q <= (wrSel == clk_div_bank_pkg::SEL_NONE) ?
				clk_div_bank_pkg::RESP_SLVERR : clk_div_bank_pkg::RESP_OKAY;
		end else if (bvalid_q && bready) begin
			bvalid_q <= 1'b0;
		end
	end

	assign bvalid = bvalid_q;
	assign bresp = bresp_q;

	////////////////////////////////////////////////////////////////////////////////
	// Buffer registers and the global update
	// Software writes reach only the buffers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bufStage1_q <= clk_div_bank_pkg::RST_COUNTS;
			bufStage2_q <= clk_div_bank_pkg::RST_COUNTS;
			bufChannel_q <= clk_div_bank_pkg::RST_CTRL;
			bufDuty_q <= clk_div_bank_pkg::RST_CTRL;
			bufRatio_q <= clk_div_bank_pkg::RST_RATIO;
			bufInput_q <= clk_div_bank_pkg::RST_CTRL;
		end else if (wrLane) begin
			case (wrSel)
				clk_div_bank_pkg::SEL_STAGE1: bufStage1_q <= wByte_q;
				clk_div_bank_pkg::SEL_STAGE2: bufStage2_q <= wByte_q;
				clk_div_bank_pkg::SEL_CHANNEL: bufChannel_q <= wByte_q & clk_div_bank_pkg::MASK_CHANNEL;
				clk_div_bank_pkg::SEL_DUTY: bufDuty_q <= wByte_q & clk_div_bank_pkg::MASK_ONE_BIT;
				clk_div_bank_pkg::SEL_RATIO: bufRatio_q <= wByte_q & clk_div_bank_pkg::MASK_RATIO;
				clk_div_bank_pkg::SEL_INPUT: bufInput_q <= wByte_q & clk_div_bank_pkg::MASK_INPUT;
				default: begin
				end
			endcase
		end
	end

	// Soft sync acts at once, so a sync can be issued without an update
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			softSync_q <= 1'b0;
		end else if (wrLane && wrSel == clk_div_bank_pkg::SEL_SOFT_SYNC) begin
			softSync_q <= wByte_q[clk_div_bank_pkg::SOFT_SYNC_BIT];
		end
	end

	// Update bit is a one-cycle request; it never reads back as one
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			updateReq_q <= 1'b0;
		end else begin
			updateReq_q <= wrLane && wrSel == clk_div_bank_pkg::SEL_UPDATE &&
				wByte_q[clk_div_bank_pkg::UPDATE_BIT];
		end
	end

	// All active copies change at one edge; no half-applied setup
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			actStage1_q <= clk_div_bank_pkg::RST_COUNTS;
			actStage2_q <= clk_div_bank_pkg::RST_COUNTS;
			actChannel_q <= clk_div_bank_pkg::RST_CTRL;
			actDuty_q <= clk_div_bank_pkg::RST_CTRL;
			actRatio_q <= clk_div_bank_pkg::RST_RATIO;
			actInput_q <= clk_div_bank_pkg::RST_CTRL;
		end else if (updateReq_q) begin
			actStage1_q <= bufStage1_q;
			actStage2_q <= bufStage2_q;
			actChannel_q <= bufChannel_q;
			actDuty_q <= bufDuty_q;
			actRatio_q <= bufRatio_q;
			actInput_q <= bufInput_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite read channel
	assign rdSel = clk_div_bank_pkg::decode_index(
		araddr[clk_div_bank_pkg::ADDR_W-1:clk_div_bank_pkg::IDX_LSB]);

	// Reads return buffer contents, so software sees what it wrote before an update
	always_comb begin
		case (rdSel)
			clk_div_bank_pkg::SEL_STAGE1: rdByte = bufStage1_q;
			clk_div_bank_pkg::SEL_STAGE2: rdByte = bufStage2_q;
			clk_div_bank_pkg::SEL_CHANNEL: rdByte = bufChannel_q;
			clk_div_bank_pkg::SEL_DUTY: rdByte = bufDuty_q;
			clk_div_bank_pkg::SEL_RATIO: rdByte = bufRatio_q;
			clk_div_bank_pkg::SEL_INPUT: rdByte = bufInput_q;
			clk_div_bank_pkg::SEL_SOFT_SYNC: rdByte = {7'h00, softSync_q};
			clk_div_bank_pkg::SEL_STATUS: rdByte = statusByte;
			default: rdByte = 8'h00;
		endcase
	end

	assign arready = !rvalid_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= clk_div_bank_pkg::RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid_q <= 1'b1;
			rdata_q <= {24'h000000, rdByte};
			rresp_q <= (rdSel == clk_div_bank_pkg::SEL_NONE) ?
				clk_div_bank_pkg::RESP_SLVERR : clk_div_bank_pkg::RESP_OKAY;
		end else if (rvalid_q && rready) begin
			rvalid_q <= 1'b0;
		end
	end

	assign rvalid = rvalid_q;
	assign rdata = rdata_q;
	assign rresp = rresp_q;

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	logic [2:0] extSync_q, oscSync_q, syncNSync_q;
	logic extLevel_q, oscLevel_q, syncLevel_q;

	// Three stages; a level is accepted only once the last two agree
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			extSync_q <= 3'h0;
			oscSync_q <= 3'h0;
			syncNSync_q <= 3'h7;
		end else begin
			extSync_q <= {extSync_q[1:0], extClkIn};
			oscSync_q <= {oscSync_q[1:0], oscClkIn};
			syncNSync_q <= {syncNSync_q[1:0], syncPin_n};
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			extLevel_q <= 1'b0;
			oscLevel_q <= 1'b0;
			syncLevel_q <= 1'b1;
		end else begin
			if (extSync_q[1] == extSync_q[2])
				extLevel_q <= extSync_q[2];
			if (oscSync_q[1] == oscSync_q[2])
				oscLevel_q <= oscSync_q[2];
			if (syncNSync_q[1] == syncNSync_q[2])
				syncLevel_q <= syncNSync_q[2];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Source selection and power-down gating
	logic pdSection, pdOscIf, pdBoth, selOsc, preBypass;
	logic extEnable, oscEnable;
	logic srcLevel, srcLevel_q, srcTick;
	logic syncActive, chanHold, nosync;

	assign pdSection = actInput_q[clk_div_bank_pkg::IN_PD_SECTION];
	assign pdOscIf = actInput_q[clk_div_bank_pkg::IN_PD_OSC_IF];
	assign pdBoth = actInput_q[clk_div_bank_pkg::IN_PD_BOTH];
	assign selOsc = actInput_q[clk_div_bank_pkg::IN_SEL_OSC];
	// Bypass is refused while the oscillator is the source
	assign preBypass = actInput_q[clk_div_bank_pkg::IN_BYPASS] && !selOsc;

	// A powered-down path delivers a steady low to the prescaler
	assign extEnable = !pdSection && !pdBoth;
	assign oscEnable = !pdSection && !pdBoth && !pdOscIf;
	assign srcLevel = selOsc ? (oscLevel_q && oscEnable) : (extLevel_q && extEnable);

	// Rising edge of the chosen source becomes the one-cycle tick for the chain
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			srcLevel_q <= 1'b0;
		else
			srcLevel_q <= srcLevel;
	end

	assign srcTick = srcLevel && !srcLevel_q;

	// Pin is active low, the soft bit active high; either one requests a sync
	assign syncActive = !syncLevel_q || softSync_q;
	assign nosync = actChannel_q[clk_div_bank_pkg::CH_NOSYNC];
	// Holding releases together for both stages, so they restart in step
	assign chanHold = pdSection || (syncActive && !nosync);

	////////////////////////////////////////////////////////////////////////////////
	// Divider chain
	logic preLevel, preTick, st1Level, st1Tick, st2Level;

	clk_prescaler prescaler (
		.clk(clk),
		.rst_n(rst_n),
		.hold(pdSection),
		.bypass(preBypass),
		.ratio(actRatio_q[2:0]),
		.inLevel(srcLevel),
		.inTick(srcTick),
		.outLevel(preLevel),
		.outTick(preTick)
	);

	clk_div_stage stageOne (
		.clk(clk),
		.rst_n(rst_n),
		.hold(chanHold),
		.bypass(actChannel_q[clk_div_bank_pkg::CH_BYPASS1]),
		.startHigh(actChannel_q[clk_div_bank_pkg::CH_START1]),
		.lowCount(actStage1_q[clk_div_bank_pkg::LOW_MSB:clk_div_bank_pkg::LOW_LSB]),
		.highCount(actStage1_q[clk_div_bank_pkg::HIGH_MSB:clk_div_bank_pkg::HIGH_LSB]),
		.inLevel(preLevel),
		.inTick(preTick),
		.outLevel(st1Level),
		.outTick(st1Tick)
	);

	clk_div_stage stageTwo (
		.clk(clk),
		.rst_n(rst_n),
		.hold(chanHold),
		.bypass(actChannel_q[clk_div_bank_pkg::CH_BYPASS2]),
		.startHigh(actChannel_q[clk_div_bank_pkg::CH_START2]),
		.lowCount(actStage2_q[clk_div_bank_pkg::LOW_MSB:clk_div_bank_pkg::LOW_LSB]),
		.highCount(actStage2_q[clk_div_bank_pkg::HIGH_MSB:clk_div_bank_pkg::HIGH_LSB]),
		.inLevel(st1Level),
		.inTick(st1Tick),
		.outLevel(st2Level),
		.outTick()
	);

	////////////////////////////////////////////////////////////////////////////////
	// Output registers
	logic chanOut_q, preOut_q;

	// Force only applies with sync-ignore set, else the divided clock goes out
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			chanOut_q <= 1'b0;
			preOut_q <= 1'b0;
		end else begin
			chanOut_q <= nosync ? actChannel_q[clk_div_bank_pkg::CH_FORCE] : st2Level;
			preOut_q <= preLevel;
		end
	end

	assign chanClkOut = chanOut_q;
	assign prescaleClkOut = preOut_q;
	// Correction itself is analog; this level turns it on or off
	assign dutyCorrectEnable = !actDuty_q[clk_div_bank_pkg::DUTY_OFF];
	assign inputSectionPowerDown = pdSection;
	assign oscPathPowerDown = !oscEnable;
	assign extInputPowerDown = !extEnable;

	// Status: live outputs, sync state and current source
	assign statusByte = {4'h0, selOsc, syncActive, preOut_q, chanOut_q};
endmodule
`default_nettype wire

// ==== tb/channel_clock_divider_bank_chk.sv ====
// Port-level assertions for the channel clock divider bank
`timescale 1ns/1ps
`default_nettype none
module channel_clock_divider_bank_chk (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic inputSectionPowerDown,
	input wire logic oscPathPowerDown,
	input wire logic extInputPowerDown
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Handshake steps
	sequence wrBoth;
		awvalid && awready && wvalid && wready;
	endsequence
	sequence rdTake;
		arvalid && arready;
	endsequence
	////////////////////////////////////////
	wr_answer_a: assert property (wrBoth |-> ##2 bvalid)
		else $error("late write answer");
	rd_answer_a: assert property (rdTake |=> rvalid)
		else $error("late read answer");
	b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped");
	r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped");
	w_refuse_a: assert property (bvalid |-> !awready && !wready)
		else $error("write taken while busy");
	r_refuse_a: assert property (rvalid |-> !arready && rdata[31:8] == 24'h0)
		else $error("read taken while busy");
	err_zero_a: assert property (rvalid && rresp == clk_div_bank_pkg::RESP_SLVERR |-> rdata == 0)
		else $error("error read returned data");
	pd_section_a: assert property (inputSectionPowerDown |-> oscPathPowerDown && extInputPowerDown)
		else $error("path left running");
	pd_both_a: assert property (extInputPowerDown |-> oscPathPowerDown)
		else $error("oscillator path running");
endmodule
bind channel_clock_divider_bank channel_clock_divider_bank_chk i_channel_clock_divider_bank_chk (
	.clk(clk), .rst_n(rst_n), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
	.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .arvalid(arvalid),
	.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
	.inputSectionPowerDown(inputSectionPowerDown), .oscPathPowerDown(oscPathPowerDown),
	.extInputPowerDown(extInputPowerDown)
);
`default_nettype wire

// ==== tb/channel_clock_divider_bank_bench.sv ====
// Self-checking bench for the channel clock divider bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e, m) begin n_compared++; if ((a) !== (e)) begin miscompares++; \
	$display("Error %0t: %s", $time, m); end end
module channel_clock_divider_bank_bench;
	logic clk = 0, rst_n = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic extClkIn = 0, oscClkIn = 0, syncPin_n = 1, monSel = 0;
	logic [13:0] awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0, rdata, q;
	logic [3:0] wstrb = 4'hf;
	logic [1:0] bresp, rresp, r;
	logic awready, wready, bvalid, arready, rvalid, chanClkOut, prescaleClkOut;
	logic dutyCorrectEnable, inputSectionPowerDown, oscPathPowerDown, extInputPowerDown;
	int miscompares = 0, n_compared = 0, cyc = 0, hi, lo, t;
	wire logic mon = monSel ? chanClkOut : prescaleClkOut;

	channel_clock_divider_bank i_channel_clock_divider_bank (
		.clk(clk), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.extClkIn(extClkIn), .oscClkIn(oscClkIn), .syncPin_n(syncPin_n),
		.chanClkOut(chanClkOut), .prescaleClkOut(prescaleClkOut),
		.dutyCorrectEnable(dutyCorrectEnable), .inputSectionPowerDown(inputSectionPowerDown),
		.oscPathPowerDown(oscPathPowerDown), .extInputPowerDown(extInputPowerDown)
	);

	always #10 clk = ~clk;
	// Sources toggled on clk so measured lengths are exact; external period 8, oscillator 12
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc % 4 == 3) extClkIn <= ~extClkIn;
		if (cyc % 6 == 5) oscClkIn <= ~oscClkIn;
		if (cyc == 30000) begin
			miscompares++;
			final_report();
		end
	end
	////////////////////////////////////////
	// Bus tasks sample ready before the edge's updates land
	task automatic wr(input logic [11:0] ix, input logic [7:0] v);
		logic a, w;
		@(posedge clk);
		a = 1;
		w = 1;
		awaddr <= {ix, 2'h0};
		wdata <= {24'h0, v};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (a || w) begin
			@(posedge clk);
			if (a && awready) begin
				a = 0;
				awvalid <= 1'b0;
			end
			if (w && wready) begin
				w = 0;
				wvalid <= 1'b0;
			end
		end
		while (bvalid !== 1'b1) @(posedge clk);
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] ix);
		@(posedge clk);
		araddr <= {ix, 2'h0};
		arvalid <= 1'b1;
		rready <= 1'b1;
		@(posedge clk);
		while (arready !== 1'b1) @(posedge clk);
		arvalid <= 1'b0;
		@(posedge clk);
		while (rvalid !== 1'b1) @(posedge clk);
		q = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	task automatic rchk(input logic [11:0] ix, input logic [7:0] e);
		rd(ix);
		`CHK({r, q}, {clk_div_bank_pkg::RESP_OKAY, 24'h0, e}, "register read")
	endtask
	// Buffered write, then global update
	task automatic upd(input logic [11:0] ix, input logic [7:0] v);
		wr(ix, v);
		wr(clk_div_bank_pkg::IDX_UPDATE, 8'h01);
		repeat (4) @(posedge clk);
	endtask
	// High and low lengths of mon; a dead output ends in the timeout
	task automatic meas;
		hi = 0;
		lo = 0;
		while (mon !== 1'b0) @(posedge clk);
		while (mon !== 1'b1) @(posedge clk);
		while (mon === 1'b1) begin
			@(posedge clk);
			hi++;
		end
		while (mon === 1'b0) begin
			@(posedge clk);
			lo++;
		end
	endtask
	task automatic quiet(input int n);
		logic p;
		t = 0;
		p = mon;
		repeat (n) begin
			@(posedge clk);
			if (mon !== p) t++;
			p = mon;
		end
	endtask
	////////////////////////////////////////
	task automatic t_regs;
		rchk(clk_div_bank_pkg::IDX_STAGE2_COUNTS, 8'h00);
		rchk(clk_div_bank_pkg::IDX_CHANNEL_CTRL, 8'h00);
		rchk(clk_div_bank_pkg::IDX_DUTY_CTRL, 8'h00);
		rchk(clk_div_bank_pkg::IDX_PRESCALER_RATIO, 8'h02);
		rchk(clk_div_bank_pkg::IDX_INPUT_CTRL, 8'h00);
		rd(12'h3ff);
		`CHK({r, q}, {clk_div_bank_pkg::RESP_SLVERR, 32'h0}, "unmapped read")
		wr(12'h3ff, 8'h55);
		`CHK(r, clk_div_bank_pkg::RESP_SLVERR, "unmapped write")
		$display("registers done");
	endtask
	task automatic t_upd;
		logic [7:0] pv [3] = '{8'h1c, 8'h08, 8'h04};
		logic [2:0] ev [4] = '{3'h0, 3'h7, 3'h2, 3'h3};
		`CHK(dutyCorrectEnable, 1'b1, "duty default")
		for (int i = 0; i < 3; i++) begin
			wr(clk_div_bank_pkg::IDX_INPUT_CTRL, pv[i]);
			rchk(clk_div_bank_pkg::IDX_INPUT_CTRL, pv[i]);
			`CHK({inputSectionPowerDown, oscPathPowerDown, extInputPowerDown}, ev[i], "early")
			upd(clk_div_bank_pkg::IDX_UPDATE, 8'h01);
			`CHK({inputSectionPowerDown, oscPathPowerDown, extInputPowerDown}, ev[i + 1], "pd")
		end
		rchk(clk_div_bank_pkg::IDX_UPDATE, 8'h00);
		upd(clk_div_bank_pkg::IDX_DUTY_CTRL, 8'h01);
		`CHK(dutyCorrectEnable, 1'b0, "duty off")
		upd(clk_div_bank_pkg::IDX_DUTY_CTRL, 8'h00);
		upd(clk_div_bank_pkg::IDX_INPUT_CTRL, 8'h00);
		$display("update done");
	endtask
	// Every ratio code, static ones included
	task automatic t_ratio;
		monSel = 0;
		for (int c = 0; c < 8; c++) begin
			upd(clk_div_bank_pkg::IDX_PRESCALER_RATIO, 8'(c));
			if (c < 5) begin
				meas();
				meas();
				`CHK({hi, lo}, {(c + 2) / 2 * 8, (c + 2 + 1) / 2 * 8}, "ratio")
			end else begin
				quiet(60);
				`CHK({t, prescaleClkOut}, {32'd0, 1'b0}, "static prescaler")
			end
		end
		$display("ratio done");
	endtask
	task automatic t_src;
		logic [7:0] sv [3] = '{8'h01, 8'h02, 8'h03};
		int ep [3] = '{8, 48, 48};
		upd(clk_div_bank_pkg::IDX_PRESCALER_RATIO, 8'h02);
		for (int i = 0; i < 3; i++) begin
			upd(clk_div_bank_pkg::IDX_INPUT_CTRL, sv[i]);
			meas();
			meas();
			`CHK(hi + lo, ep[i], "source period")
		end
		upd(clk_div_bank_pkg::IDX_INPUT_CTRL, 8'h00);
		upd(clk_div_bank_pkg::IDX_PRESCALER_RATIO, 8'h00);
		$display("source done");
	endtask
	// Prescaler now divides by two: one stage input cycle is 16 clocks
	task automatic t_stage;
		logic [7:0] cv [5] = '{8'h10, 8'h10, 8'h30, 8'h20, 8'h00};
		logic [7:0] s1 [5] = '{8'h00, 8'h00, 8'h21, 8'h21, 8'h00};
		logic [7:0] s2 [5] = '{8'h21, 8'h00, 8'h21, 8'h00, 8'h00};
		int eh [5] = '{32, 16, 8, 32, 32};
		int el [5] = '{48, 16, 8, 48, 32};
		monSel = 1;
		for (int i = 0; i < 5; i++) begin
			wr(clk_div_bank_pkg::IDX_CHANNEL_CTRL, cv[i]);
			wr(clk_div_bank_pkg::IDX_STAGE1_COUNTS, s1[i]);
			upd(clk_div_bank_pkg::IDX_STAGE2_COUNTS, s2[i]);
			meas();
			meas();
			`CHK({hi, lo}, {eh[i], el[i]}, "stage lengths")
		end
		$display("stage done");
	endtask
	// Long phases keep the start level showing after release
	task automatic t_sync;
		logic [7:0] cv [4] = '{8'h10, 8'h12, 8'h20, 8'h21};
		logic es [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
		upd(clk_div_bank_pkg::IDX_CHANNEL_CTRL, 8'h0c);
		quiet(40);
		`CHK({t, chanClkOut}, {32'd0, 1'b1}, "forced high")
		upd(clk_div_bank_pkg::IDX_CHANNEL_CTRL, 8'h08);
		quiet(40);
		`CHK({t, chanClkOut}, {32'd0, 1'b0}, "forced low")
		wr(clk_div_bank_pkg::IDX_STAGE1_COUNTS, 8'hff);
		for (int i = 0; i < 4; i++) begin
			upd(clk_div_bank_pkg::IDX_STAGE2_COUNTS, 8'hff);
			upd(clk_div_bank_pkg::IDX_CHANNEL_CTRL, cv[i]);
			syncPin_n <= 1'b0;
			repeat (10) @(posedge clk);
			quiet(60);
			`CHK(t, 0, "held during sync")
			syncPin_n <= 1'b1;
			repeat (8) @(posedge clk);
			`CHK(chanClkOut, es[i], "start level")
		end
		wr(clk_div_bank_pkg::IDX_SOFT_SYNC, 8'h01);
		quiet(60);
		rd(clk_div_bank_pkg::IDX_STATUS);
		`CHK({t, q[2]}, {32'd0, 1'b1}, "soft sync")
		wr(clk_div_bank_pkg::IDX_SOFT_SYNC, 8'h00);
		$display("sync done");
	endtask
	////////////////////////////////////////
	task automatic final_report;
		$display("compared %0d, mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_upd();
		t_ratio();
		t_src();
		t_stage();
		t_sync();
		final_report();
	end
endmodule
`default_nettype wire
